// ---- rtl/plic_defs.vh ----
// Constants for the program-level interrupt control block.
// Assumes a 125 MHz clock and 16-bit instruction words.
`ifndef PLIC_DEFS_VH
`define PLIC_DEFS_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define LEVEL_COUNT        16
`define SYNC_WIDTH         16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MASK_RESET         16'h0000
`define DETECT_RESET       16'h0000
`define LEVEL_RESET        4'h0

// ----------------------------------------
// Level numbers and bit positions
// ----------------------------------------
`define LEVEL_HW_STATUS    4'he
`define LEVEL_ZERO         4'h0
`define VEC_LEVEL_BASE     4'ha

// ----------------------------------------
// Synchroniser bit positions
// ----------------------------------------
`define SYNC_EXT_LSB       0
`define SYNC_CONTINUE      5
`define SYNC_ID_ACK        6
`define SYNC_ID_LSB        7

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define OP_SYS_ON          16'hd102
`define OP_SYS_OFF         16'hd101
`define OP_IDENT10         16'hc784
`define OP_IDENT11         16'hc789
`define OP_IDENT12         16'hc792
`define OP_IDENT13         16'hc7a3
`define OP_MONITOR_HI      8'hd6
`define OP_WAIT_HI         8'hd2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS      8
`define IDENT_TIME_NS      1900
`define IDENT_WAIT_CYC     (`IDENT_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/pin_synchronizer.v ----
// Two-stage synchroniser for a group of independent pin inputs.
// Assumes each bit is stable long enough to be seen by the second stage.
`timescale 1ns/10ps
`default_nettype none

module pin_synchronizer
#(
	parameter WIDTH = 16
)
(
	input  wire             clk,
	input  wire             rst_n,
	input  wire             clkEn,
	input  wire [WIDTH-1:0] pinIn,
	output wire [WIDTH-1:0] syncOut
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : stage
			reg firstReg;
			reg secondReg;
			always @(posedge clk)
			begin
				if (!rst_n)
				begin
					firstReg  <= 1'b0;
					secondReg <= 1'b0;
				end
				else if (clkEn)
				begin
					firstReg  <= pinIn[i];
					secondReg <= firstReg;
				end
			end
			assign syncOut[i] = secondReg;
		end
	endgenerate

endmodule

`default_nettype wire

// ---- rtl/level_priority_encoder.v ----
// Finds the highest set bit of a 16-bit level vector.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none

module level_priority_encoder
(
	input  wire [15:0] levelVec,
	output reg  [3:0]  topLevel,
	output reg         anySet
);

	integer k;

	always @*
	begin
		topLevel = 4'h0;
		anySet   = 1'b0;
		for (k = 0; k < 16; k = k + 1)
		begin
			if (levelVec[k])
			begin
				topLevel = k[3:0];
				anySet   = 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ---- rtl/priority_level_interrupt_control.v ----
// Program-level interrupt control: enable mask, detect flags, running level,
// and the system control instructions that act on them.
// Assumes instructions arrive as one-cycle strobes from the CPU on clk, and
// peripheral and panel signals arrive asynchronously on pins.
`include "plic_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module priority_level_interrupt_control
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire        clkEn,
	input  wire        instrValid,
	input  wire [15:0] instrWord,
	input  wire        privilegeOk,
	input  wire        maskWriteEn,
	input  wire [15:0] maskWriteData,
	input  wire        detectWriteEn,
	input  wire [15:0] detectWriteData,
	input  wire        hwStatusReq,
	input  wire        ioxErrorEnable,
	input  wire [4:0]  extLevelReq,
	input  wire        panelContinue,
	input  wire        identAck,
	input  wire [8:0]  identCode,
	output reg  [15:0] levelEnableMask,
	output reg  [15:0] levelDetectFlags,
	output reg  [3:0]  currentLevel,
	output reg  [3:0]  registerBank,
	output reg         interruptOnLamp,
	output reg         stopLamp,
	output reg  [15:0] instructionRegister,
	output reg         instrDone,
	output reg         privilegeFault,
	output reg         identReq,
	output reg  [1:0]  identLevel,
	output reg         accumLoad,
	output reg  [15:0] accumData,
	output reg         tRegLoad,
	output reg  [15:0] tRegData,
	output reg         ioxError,
	output reg         levelSwitch
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [1:0] ST_RUN   = 2'b00;
	localparam [1:0] ST_IDENT = 2'b01;
	localparam [1:0] ST_HALT  = 2'b10;

	localparam integer IDENT_WAIT_FULL = `IDENT_WAIT_CYC;
	localparam [7:0]   IDENT_WAIT      = IDENT_WAIT_FULL[7:0];

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Returns 3'b1xx for an identify code, with the vectored level offset low.
	function [2:0] identDecode;
		input [15:0] word;
		begin
			case (word)
				`OP_IDENT10: identDecode = 3'b100;
				`OP_IDENT11: identDecode = 3'b101;
				`OP_IDENT12: identDecode = 3'b110;
				`OP_IDENT13: identDecode = 3'b111;
				default:     identDecode = 3'b000;
			endcase
		end
	endfunction

	wire [2:0] identSel  = identDecode(instrWord);
	wire       isSysOn   = (instrWord == `OP_SYS_ON);
	wire       isSysOff  = (instrWord == `OP_SYS_OFF);
	wire       isIdent   = identSel[2];
	wire       isMonitor = (instrWord[15:8] == `OP_MONITOR_HI);
	wire       isWait    = (instrWord[15:8] == `OP_WAIT_HI);
	wire       isPriv    = isSysOn | isSysOff | isIdent | isWait;
	wire       allowed   = ~isPriv | privilegeOk;

	// ----------------------------------------
	// Synchronised pins
	// ----------------------------------------
	wire [15:0] syncPins;

	pin_synchronizer #(.WIDTH(`SYNC_WIDTH)) pinSync
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.pinIn   ({identCode, identAck, panelContinue, extLevelReq}),
		.syncOut (syncPins)
	);

	wire [4:0] extSync      = syncPins[`SYNC_EXT_LSB +: 5];
	wire       continueSync = syncPins[`SYNC_CONTINUE];
	wire       ackSync      = syncPins[`SYNC_ID_ACK];
	wire [8:0] codeSync     = syncPins[`SYNC_ID_LSB +: 9];

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg        sysOn_reg;
	reg        sysOn_next;
	reg [7:0]  waitCnt_reg;
	reg [7:0]  waitCnt_next;
	reg [15:0] detect_next;
	reg [15:0] detectClear;
	reg        monitorSet;
	reg        identMiss;
	reg        continueSeen_reg;

	wire       accept = instrValid & (state_reg == ST_RUN);

	// ----------------------------------------
	// Running level selection
	// ----------------------------------------
	wire [15:0] eligible = levelEnableMask & levelDetectFlags;
	wire [3:0]  topLevel;
	wire        anyPending;

	level_priority_encoder levelEnc
	(
		.levelVec (eligible),
		.topLevel (topLevel),
		.anySet   (anyPending)
	);

	// Nothing pending falls back to level zero.
	wire [3:0] targetLevel = anyPending ? topLevel : `LEVEL_ZERO;

	// Hardware request bits; only the five external levels plus level 14.
	wire [15:0] hwSet = {extSync[4], hwStatusReq | monitorSet | identMiss,
	                     extSync[3:0], 10'h000};

	// ----------------------------------------
	// Instruction sequencing
	// ----------------------------------------
	always @*
	begin
		state_next   = state_reg;
		sysOn_next   = sysOn_reg;
		waitCnt_next = waitCnt_reg;
		detectClear  = 16'h0000;
		monitorSet   = 1'b0;
		identMiss    = 1'b0;
		case (state_reg)
			ST_RUN:
			begin
				if (accept && allowed)
				begin
					if (isSysOn)
						sysOn_next = 1'b1;
					else if (isSysOff)
						sysOn_next = 1'b0;
					else if (isIdent)
					begin
						state_next   = ST_IDENT;
						waitCnt_next = IDENT_WAIT;
					end
					else if (isMonitor)
						monitorSet = 1'b1;
					else if (isWait)
					begin
						if (!sysOn_reg)
							state_next = ST_HALT;
						else if (currentLevel != `LEVEL_ZERO)
							detectClear[currentLevel] = 1'b1;
					end
				end
			end
			ST_IDENT:
			begin
				if (ackSync)
					state_next = ST_RUN;
				else if (waitCnt_reg == 8'h00)
				begin
					state_next = ST_RUN;
					identMiss  = ioxErrorEnable;
				end
				else
					waitCnt_next = waitCnt_reg - 8'h01;
			end
			ST_HALT:
			begin
				if (continueSync && !continueSeen_reg)
					state_next = ST_RUN;
			end
			default:
				state_next = ST_RUN;
		endcase
	end

	// Program write first, instruction clear next, hardware set wins last.
	always @*
	begin
		detect_next = levelDetectFlags;
		if (detectWriteEn)
			detect_next = detectWriteData;
		detect_next = (detect_next & ~detectClear) | hwSet;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg           <= ST_RUN;
			sysOn_reg           <= 1'b0;
			waitCnt_reg         <= 8'h00;
			continueSeen_reg    <= 1'b0;
			levelEnableMask     <= `MASK_RESET;
			levelDetectFlags    <= `DETECT_RESET;
			currentLevel        <= `LEVEL_RESET;
			registerBank        <= `LEVEL_RESET;
			interruptOnLamp     <= 1'b0;
			stopLamp            <= 1'b0;
			instructionRegister <= 16'h0000;
			instrDone           <= 1'b0;
			privilegeFault      <= 1'b0;
			identReq            <= 1'b0;
			identLevel          <= 2'b00;
			accumLoad           <= 1'b0;
			accumData           <= 16'h0000;
			tRegLoad            <= 1'b0;
			tRegData            <= 16'h0000;
			ioxError            <= 1'b0;
			levelSwitch         <= 1'b0;
		end
		else if (clkEn)
		begin
			state_reg        <= state_next;
			sysOn_reg        <= sysOn_next;
			waitCnt_reg      <= waitCnt_next;
			continueSeen_reg <= continueSync;
			if (maskWriteEn)
				levelEnableMask <= maskWriteData;
			levelDetectFlags <= detect_next;

			// Switching runs only with the system on; the level that issued
			// the system-on instruction has already completed it.
			if (sysOn_reg && targetLevel != currentLevel)
			begin
				currentLevel <= targetLevel;
				registerBank <= targetLevel;
				levelSwitch  <= 1'b1;
			end
			else
				levelSwitch <= 1'b0;

			if (accept)
				instructionRegister <= instrWord;

			if (accept && allowed && isSysOn)
				interruptOnLamp <= 1'b1;
			else if (accept && allowed && isSysOff)
				interruptOnLamp <= 1'b0;

			stopLamp <= (state_next == ST_HALT);

			privilegeFault <= accept & ~allowed;

			identReq <= accept & allowed & isIdent;
			if (accept && allowed && isIdent)
				identLevel <= identSel[1:0];

			accumLoad <= (state_reg == ST_IDENT) & ackSync;
			if (state_reg == ST_IDENT && ackSync)
				accumData <= {7'h00, codeSync};

			tRegLoad <= monitorSet;
			if (monitorSet)
				tRegData <= {{8{instrWord[7]}}, instrWord[7:0]};

			ioxError <= (state_reg == ST_IDENT) & ~ackSync & (waitCnt_reg == 8'h00);

			// Done marks completion; a halting wait completes when released.
			instrDone <= (accept & ~(allowed & isIdent) & ~(allowed & isWait & ~sysOn_reg))
			           | ((state_reg == ST_IDENT) & (state_next == ST_RUN))
			           | ((state_reg == ST_HALT) & (state_next == ST_RUN));
		end
	end

endmodule

`default_nettype wire

// ---- verif/plic_check_sva.sv ----
// Assertions on the ports of the program-level interrupt control block.
// Assumes the constants header is on the include path; bound at the foot.
`timescale 1ns/10ps
`default_nettype none
`include "plic_defs.vh"

module plic_check
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        instrValid,
	input wire logic [15:0] instrWord,
	input wire logic        privilegeOk,
	input wire logic [15:0] levelEnableMask,
	input wire logic [15:0] levelDetectFlags,
	input wire logic [3:0]  currentLevel,
	input wire logic [3:0]  registerBank,
	input wire logic        interruptOnLamp,
	input wire logic        stopLamp,
	input wire logic        instrDone,
	input wire logic        privilegeFault,
	input wire logic        identReq,
	input wire logic        accumLoad,
	input wire logic [15:0] accumData,
	input wire logic [8:0]  identCode,
	input wire logic        tRegLoad,
	input wire logic [15:0] tRegData,
	input wire logic        ioxError
);
	logic             busy;
	wire logic [15:0] both = levelEnableMask & levelDetectFlags;

	function automatic logic [3:0] top(input logic [15:0] v);
		top = 4'h0;
		for (int i = 0; i < 16; i++)
			if (v[i])
				top = i[3:0];
	endfunction

	// Marks an identify cycle in progress, when new instructions are ignored.
	always_ff @(posedge clk)
		busy <= rst_n && (identReq || (busy && !instrDone));

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_waitOn;
		instrValid && privilegeOk && interruptOnLamp && !busy && !identReq
			&& instrWord[15:8] == `OP_WAIT_HI && currentLevel != 4'h0;
	endsequence
	sequence s_identEnd;
		##[1:250] instrDone && (accumLoad || ioxError);
	endsequence

	AST_LEVEL_TOP: assert property ($past(interruptOnLamp) && interruptOnLamp && $stable(both)
		|-> currentLevel == top(both)) else $error("running level is not the top pending level");
	AST_BANK: assert property (registerBank == currentLevel)
		else $error("register set differs from running level");
	AST_LAMP_ON: assert property ($rose(interruptOnLamp)
		|-> $past(instrValid && privilegeOk && instrWord == `OP_SYS_ON)) else $error("lamp lit without system on");
	AST_OFF_HOLD: assert property (!interruptOnLamp && !$past(interruptOnLamp)
		|-> $stable(currentLevel)) else $error("level moved with system off");
	AST_PRIV: assert property (privilegeFault |-> instrDone && $past(instrValid && !privilegeOk))
		else $error("fault without refused instruction");
	AST_MON: assert property (tRegLoad |-> levelDetectFlags[14] && instrDone
		&& tRegData == {{8{$past(instrWord[7])}}, $past(instrWord[7:0])}) else $error("monitor call result wrong");
	AST_ACCUM: assert property (accumLoad
		|-> accumData == {7'h00, $past(identCode, 3)}) else $error("identify result wrong");
	AST_IDENT_END: assert property (identReq |-> s_identEnd)
		else $error("identify cycle did not finish");
	AST_WAIT_ON: assert property (s_waitOn |=> levelDetectFlags[$past(currentLevel)] == 1'b0 && instrDone)
		else $error("wait kept its detect bit");
	AST_STOP: assert property ($rose(stopLamp)
		|-> $past(instrValid && privilegeOk && !interruptOnLamp && instrWord[15:8] == `OP_WAIT_HI))
		else $error("stop lamp lit without wait");
endmodule

bind priority_level_interrupt_control plic_check chk (.clk, .rst_n, .instrValid, .instrWord, .privilegeOk,
	.levelEnableMask, .levelDetectFlags, .currentLevel, .registerBank, .interruptOnLamp, .stopLamp,
	.instrDone, .privilegeFault, .identReq, .accumLoad, .accumData, .identCode, .tRegLoad, .tRegData, .ioxError);
`default_nettype wire

// ---- verif/periph_model.sv ----
// Peripheral on vectored level 10 that answers identify cycles.
// Assumes identify requests arrive as one-cycle pulses on the block's clock.
`timescale 1ns/10ps
`default_nettype none

module periph_model
#(
	parameter logic [8:0] CODE = 9'h0a5
)
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       raise,
	input  wire logic       slow,
	input  wire logic       identReq,
	input  wire logic [1:0] identLevel,
	output var  logic       reqLine,
	output wire logic       ack,
	output wire logic [8:0] code
);
	int cnt;

	always @(posedge clk)
		if (!rst_n)
		begin
			reqLine <= 1'b0;
			cnt     <= 0;
		end
		else
		begin
			if (raise)
				reqLine <= 1'b1;
			if (identReq && identLevel == 2'h0 && reqLine)
				cnt <= slow ? 66 : 8;
			else if (cnt > 0)
				cnt <= cnt - 1;
			if (cnt == 7)
				reqLine <= 1'b0;
		end

	// The code lines show a scrambled value whenever the answer is withdrawn.
	assign ack  = cnt > 0 && cnt < 7;
	assign code = ack ? CODE : ~CODE;
endmodule
`default_nettype wire

// ---- verif/priority_level_interrupt_control_tb.sv ----
// Self-checking bench for the program-level interrupt control block.
// Assumes the constants header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "plic_defs.vh"

module priority_level_interrupt_control_tb;
	localparam logic [8:0] idCode = 9'h0a5;
	logic        clk, rst_n, clkEn, instrValid, privilegeOk, maskWriteEn, detectWriteEn, hwStatusReq;
	logic        ioxErrorEnable, panelContinue, raise, slow, identAck, reqTen, levelSwitch;
	logic        interruptOnLamp, stopLamp, instrDone, privilegeFault, identReq, accumLoad, tRegLoad, ioxError;
	logic [15:0] instrWord, maskWriteData, detectWriteData, levelEnableMask, levelDetectFlags;
	logic [15:0] instructionRegister, accumData, tRegData;
	logic [3:0]  extHi, currentLevel, registerBank;
	logic [8:0]  identCode;
	logic [1:0]  identLevel;
	int          err_total, checks_done;

	priority_level_interrupt_control dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .instrValid(instrValid),
		.instrWord(instrWord), .privilegeOk(privilegeOk), .maskWriteEn(maskWriteEn), .maskWriteData(maskWriteData),
		.detectWriteEn(detectWriteEn), .detectWriteData(detectWriteData), .hwStatusReq(hwStatusReq),
		.ioxErrorEnable(ioxErrorEnable), .extLevelReq({extHi, reqTen}), .panelContinue(panelContinue),
		.identAck(identAck), .identCode(identCode), .levelEnableMask(levelEnableMask),
		.levelDetectFlags(levelDetectFlags), .currentLevel(currentLevel), .registerBank(registerBank),
		.interruptOnLamp(interruptOnLamp), .stopLamp(stopLamp), .instructionRegister(instructionRegister),
		.instrDone(instrDone), .privilegeFault(privilegeFault), .identReq(identReq), .identLevel(identLevel),
		.accumLoad(accumLoad), .accumData(accumData), .tRegLoad(tRegLoad), .tRegData(tRegData),
		.ioxError(ioxError), .levelSwitch(levelSwitch));
	periph_model #(.CODE(idCode)) pm (.clk, .rst_n, .raise, .slow, .identReq, .identLevel,
		.reqLine(reqTen), .ack(identAck), .code(identCode));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks=%0d errors=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic exec(input logic [15:0] w, input logic ok);
		instrValid = 1'b1;
		instrWord = w;
		privilegeOk = ok;
		tick(1);
		instrValid = 1'b0;
	endtask

	task automatic wr(input logic [15:0] d);
		maskWriteEn = 1'b1;
		maskWriteData = 16'hffff;
		detectWriteEn = 1'b1;
		detectWriteData = d;
		tick(1);
		maskWriteEn = 1'b0;
		detectWriteEn = 1'b0;
		tick(2);
	endtask

	task automatic waitDone;
		int n;
		for (n = 0; n < 300 && instrDone !== 1'b1; n++)
			tick(1);
		if (n == 300)
		begin
			err_total++;
			give_verdict;
		end
	endtask

	task automatic s_level;
		chk(levelDetectFlags, 16'h0000);
		wr(16'h0410);
		chk(levelEnableMask, 16'hffff);
		chk(16'(currentLevel), 16'h0000);
		exec(`OP_SYS_ON, 1'b0);
		chk(16'(privilegeFault), 16'h0001);
		tick(1);
		chk(16'(interruptOnLamp), 16'h0000);
		exec(`OP_SYS_ON, 1'b1);
		chk(16'(interruptOnLamp), 16'h0001);
		chk(16'(currentLevel), 16'h0000);
		tick(1);
		chk(16'(registerBank), 16'h000a);
		chk(16'(levelSwitch), 16'h0001);
	endtask

	task automatic s_waitOn;
		exec({`OP_WAIT_HI, 8'hff}, 1'b1);
		chk(instructionRegister, 16'hd2ff);
		chk(levelDetectFlags, 16'h0010);
		tick(1);
		chk(16'(currentLevel), 16'h0004);
		exec({`OP_WAIT_HI, 8'h00}, 1'b1);
		tick(1);
		wr(16'h0001);
		exec({`OP_WAIT_HI, 8'h01}, 1'b1);
		tick(1);
		chk(16'(currentLevel), 16'h0000);
		chk(levelDetectFlags, 16'h0001);
	endtask

	task automatic s_ext;
		logic [3:0]  lv [4] = '{4'hb, 4'hc, 4'hd, 4'hf};
		logic [15:0] e = 16'h0001;
		for (int i = 0; i < 4; i++)
		begin
			extHi = extHi | (4'h1 << i);
			tick(5);
			e = e | (16'h0001 << lv[i]);
			chk(levelDetectFlags, e);
			chk(16'(currentLevel), 16'(lv[i]));
		end
		extHi = 4'h0;
		tick(3);
		wr(16'h0100);
		exec(`OP_SYS_OFF, 1'b1);
		chk(16'(interruptOnLamp), 16'h0000);
		wr(16'h8001);
		chk(16'(currentLevel), 16'h0008);
	endtask

	task automatic s_ident;
		logic [15:0] ops [4] = '{`OP_IDENT10, `OP_IDENT11, `OP_IDENT12, `OP_IDENT13};
		for (int i = 0; i < 5; i++)
		begin
			slow = (i == 4);
			raise = (i % 4 == 0);
			wr(16'h0000);
			raise = 1'b0;
			tick(3);
			exec(ops[i % 4], 1'b1);
			chk(16'(identLevel), 16'(i % 4));
			waitDone;
			chk(16'(ioxError), 16'(i % 4 != 0));
			tick(2);
			chk(accumData, {7'h00, idCode});
			chk(16'(levelDetectFlags[14]), 16'(i % 4 != 0));
			chk(16'(reqTen), 16'h0000);
		end
	endtask

	task automatic s_monHalt;
		wr(16'h0000);
		exec({`OP_MONITOR_HI, 8'h80}, 1'b0);
		chk(tRegData, 16'hff80);
		chk(levelDetectFlags, 16'h4000);
		chk(16'(privilegeFault), 16'h0000);
		wr(16'h0000);
		hwStatusReq = 1'b1;
		tick(2);
		hwStatusReq = 1'b0;
		chk(levelDetectFlags, 16'h4000);
		exec({`OP_WAIT_HI, 8'h05}, 1'b1);
		tick(4);
		chk(16'(stopLamp), 16'h0001);
		panelContinue = 1'b1;
		waitDone;
		panelContinue = 1'b0;
		chk(16'(stopLamp), 16'h0000);
		chk(16'(currentLevel), 16'h0008);
	endtask

	task automatic s_freeze;
		clkEn = 1'b0;
		wr(16'h0001);
		exec(`OP_SYS_ON, 1'b1);
		chk(levelDetectFlags, 16'h4000);
		chk(16'(interruptOnLamp), 16'h0000);
		clkEn = 1'b1;
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(1);
		chk(levelDetectFlags, 16'h0000);
		chk(16'(currentLevel), 16'h0000);
		chk(16'(registerBank), 16'h0000);
	endtask

	initial
	begin
		{rst_n, instrValid, privilegeOk, maskWriteEn, detectWriteEn, hwStatusReq} = 6'h00;
		{panelContinue, raise, slow, extHi, instrWord, maskWriteData, detectWriteData} = 55'h0;
		ioxErrorEnable = 1'b1;
		clkEn = 1'b1;
		err_total = 0;
		checks_done = 0;
		tick(20);
		rst_n = 1'b1;
		tick(1);
		s_level;
		s_waitOn;
		s_ext;
		s_ident;
		s_monHalt;
		s_freeze;
		give_verdict;
	end
endmodule
`default_nettype wire
